// >>> hdl/msq_reset_map.vh
`ifndef MSQ_RESET_MAP_VH
`define MSQ_RESET_MAP_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define MSQ_ADDR_SYS_CTRL     8'h00
`define MSQ_ADDR_WDT_CTRL     8'h01
`define MSQ_ADDR_RST_STATUS   8'h02
`define MSQ_ADDR_IRQ_STATUS   8'h03
`define MSQ_ADDR_IRQ_MASK     8'h04

// ----------------------------------------
// field positions
// ----------------------------------------
`define MSQ_CTRL_SYSCLK_KEEP  7
`define MSQ_CTRL_UNUSED       6
`define MSQ_CTRL_DROP_FLAG    2
`define MSQ_CTRL_SPARE        1
`define MSQ_CTRL_SOFT_FLAG    0
`define MSQ_STAT_TIMEOUT      0
`define MSQ_STAT_PWR_DOWN     1
`define MSQ_EV_DROP           0
`define MSQ_EV_WDT_RUN        1
`define MSQ_EV_WDT_SLEEP      2
`define MSQ_EV_KEY            3

// ----------------------------------------
// reset values and keys
// ----------------------------------------
`define MSQ_CTRL_RESET        8'h00
`define MSQ_WDT_CTRL_RESET    8'h53
`define MSQ_KEY_A             5'h0A
`define MSQ_KEY_B             5'h15

// ----------------------------------------
// timing
// ----------------------------------------
`define MSQ_CLK_PERIOD_NS     5
`define MSQ_CLK_MHZ           200
`define MSQ_POR_DELAY_US      50000
`define MSQ_WDT_DELAY_US      16700
`define MSQ_MIN_LOW_NS        1000
`define MSQ_WAKE_FAST_TICKS   11'h010
`define MSQ_WAKE_SLOW_TICKS   11'h002
`define MSQ_WAKE_XTAL_TICKS   11'h400
`define MSQ_KEY_DEBOUNCE      2'h1

`endif

// >>> hdl/msq_reset_seq.v
`timescale 1ns/100ps
`include "msq_reset_map.vh"

module msq_reset_seq #(
    parameter [23:0] POR_HOLD_CYC = `MSQ_POR_DELAY_US * `MSQ_CLK_MHZ,
    parameter [23:0] WDT_HOLD_CYC = `MSQ_WDT_DELAY_US * `MSQ_CLK_MHZ
) (
    input  wire       ref_clk,
    input  wire       rst_b,
    input  wire       supply_low_in,
    input  wire       wdt_timeout_in,
    input  wire       sleep_mode,
    input  wire       idle_mode,
    input  wire [1:0] osc_src,
    input  wire       sys_osc_tick,
    input  wire       slow_osc_tick,
    input  wire       flag_clear,
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    output reg        core_reset_reg,
    output reg        pc_zero_reg,
    output reg        sp_top_reg,
    output reg        sp_zero_reg,
    output reg        port_preset_reg,
    output reg        int_off_reg,
    output reg        timer_off_reg,
    output reg        wdt_clear_reg,
    output reg        wake_hold_reg,
    output reg        wdt_enable_reg,
    output reg  [2:0] wdt_period_reg,
    output reg        idle_sysclk_keep,
    output reg  [1:0] fast_osc_freq_sel,
    output reg        crystal_low_power,
    output reg        irq_reg
);

// ----------------------------------------
// constants
// ----------------------------------------
localparam [1:0] ST_HOLD = 2'd0;
localparam [1:0] ST_RUN  = 2'd1;
localparam [1:0] ST_WAKE = 2'd2;
localparam [15:0] LOW_CYC =
    (`MSQ_MIN_LOW_NS + `MSQ_CLK_PERIOD_NS - 1) / `MSQ_CLK_PERIOD_NS;

// ----------------------------------------
// state
// ----------------------------------------
reg  [1:0]  state_reg;
reg  [1:0]  state_next;
reg  [23:0] hold_cnt_reg;
reg  [23:0] hold_tgt_reg;
reg  [23:0] hold_tgt_next;
reg  [10:0] wake_cnt_reg;
reg  [10:0] wake_tgt;
reg  [15:0] low_cnt_reg;
reg         sup_s1_reg;
reg         sup_s2_reg;
reg         sup_s3_reg;
reg         low_stable_reg;
reg  [1:0]  key_ticks_reg;
reg  [7:0]  ctrl_reg;
reg  [7:0]  wdtc_reg;
reg         timeout_flag;
reg         power_down_flag;
reg  [3:0]  irq_st_reg;
reg  [3:0]  irq_mask_reg;
reg  [7:0]  rd_mux;

wire        low_power;
wire        key_bad;
wire        drop_ev;
wire        key_ev;
wire        wdt_run_ev;
wire        wdt_slp_ev;
wire        full_ev;
wire [3:0]  ev_vec;
wire        wr_ctrl;
wire        wr_wdtc;
wire        wr_istat;
wire        wr_imask;

// ----------------------------------------
// events
// ----------------------------------------
// supply monitor off while sleeping or idle
assign low_power  = sleep_mode | idle_mode;
assign drop_ev    = (state_reg != ST_HOLD) & ~low_power & low_stable_reg
                    & (low_cnt_reg == LOW_CYC);
assign key_bad    = (wdtc_reg[7:3] != `MSQ_KEY_A) & (wdtc_reg[7:3] != `MSQ_KEY_B);
assign key_ev     = key_bad & slow_osc_tick & (state_reg != ST_HOLD)
                    & (key_ticks_reg == `MSQ_KEY_DEBOUNCE);
assign wdt_run_ev = (state_reg == ST_RUN) & wdt_timeout_in & ~low_power;
assign wdt_slp_ev = (state_reg == ST_RUN) & wdt_timeout_in & low_power;
assign full_ev    = drop_ev | key_ev | wdt_run_ev;
assign ev_vec     = {key_ev, wdt_slp_ev, wdt_run_ev, drop_ev};

// write decode
assign wr_ctrl  = reg_wr & (reg_addr == `MSQ_ADDR_SYS_CTRL);
assign wr_wdtc  = reg_wr & (reg_addr == `MSQ_ADDR_WDT_CTRL);
assign wr_istat = reg_wr & (reg_addr == `MSQ_ADDR_IRQ_STATUS);
assign wr_imask = reg_wr & (reg_addr == `MSQ_ADDR_IRQ_MASK);

// ----------------------------------------
// supply input sync and filter
// ----------------------------------------
// three stages, level accepted when last two agree
always @(posedge ref_clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        sup_s1_reg     <= 1'b0;
        sup_s2_reg     <= 1'b0;
        sup_s3_reg     <= 1'b0;
        low_stable_reg <= 1'b0;
    end
    else
    begin
        sup_s1_reg <= supply_low_in;
        sup_s2_reg <= sup_s1_reg;
        sup_s3_reg <= sup_s2_reg;
        if (sup_s2_reg == sup_s3_reg)
            low_stable_reg <= sup_s3_reg;
    end
end

// low must persist past minimum time
always @(posedge ref_clk or negedge rst_b)
begin
    if (!rst_b)
        low_cnt_reg <= 16'h0000;
    else if (!low_stable_reg || low_power)
        low_cnt_reg <= 16'h0000;
    else if (low_cnt_reg != LOW_CYC)
        low_cnt_reg <= low_cnt_reg + 16'h0001;
end

// ----------------------------------------
// key debounce on slow oscillator
// ----------------------------------------
always @(posedge ref_clk or negedge rst_b)
begin
    if (!rst_b)
        key_ticks_reg <= 2'h0;
    else if (!key_bad || key_ev)
        key_ticks_reg <= 2'h0;
    else if (slow_osc_tick)
        key_ticks_reg <= key_ticks_reg + 2'h1;
end

// ----------------------------------------
// sequencer
// ----------------------------------------
// wake delay per system oscillator source
always @*
begin
    case (osc_src)
        2'd0:    wake_tgt = `MSQ_WAKE_FAST_TICKS;
        2'd1:    wake_tgt = `MSQ_WAKE_SLOW_TICKS;
        default: wake_tgt = `MSQ_WAKE_XTAL_TICKS;
    endcase
end

// next state and hold length
always @*
begin
    state_next    = state_reg;
    hold_tgt_next = hold_tgt_reg;
    case (state_reg)
        ST_HOLD:
        begin
            if (hold_cnt_reg == hold_tgt_reg)
                state_next = ST_RUN;
        end
        ST_RUN:
        begin
            if (full_ev)
            begin
                state_next = ST_HOLD;
                if (drop_ev)
                    hold_tgt_next = POR_HOLD_CYC;
                else
                    hold_tgt_next = WDT_HOLD_CYC;
            end
            else if (wdt_slp_ev)
                state_next = ST_WAKE;
        end
        ST_WAKE:
        begin
            // drop and key resets still win over the wake delay
            if (drop_ev)
            begin
                state_next    = ST_HOLD;
                hold_tgt_next = POR_HOLD_CYC;
            end
            else if (key_ev)
            begin
                state_next    = ST_HOLD;
                hold_tgt_next = WDT_HOLD_CYC;
            end
            else if (sys_osc_tick && (wake_cnt_reg + 11'h001 == wake_tgt))
                state_next = ST_RUN;
        end
        default:
            state_next = ST_HOLD;
    endcase
end

// state, counters and reset outputs
always @(posedge ref_clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        state_reg       <= ST_HOLD;
        hold_tgt_reg    <= POR_HOLD_CYC;
        hold_cnt_reg    <= 24'h00_0000;
        wake_cnt_reg    <= 11'h000;
        core_reset_reg  <= 1'b1;
        pc_zero_reg     <= 1'b1;
        sp_top_reg      <= 1'b1;
        sp_zero_reg     <= 1'b0;
        port_preset_reg <= 1'b1;
        int_off_reg     <= 1'b1;
        timer_off_reg   <= 1'b1;
        wdt_clear_reg   <= 1'b1;
        wake_hold_reg   <= 1'b0;
    end
    else
    begin
        state_reg    <= state_next;
        hold_tgt_reg <= hold_tgt_next;
        // restart hold while supply still low
        if (state_next != ST_HOLD || state_reg != ST_HOLD || low_stable_reg)
            hold_cnt_reg <= 24'h00_0000;
        else
            hold_cnt_reg <= hold_cnt_reg + 24'h00_0001;
        if (state_next != ST_WAKE || state_reg != ST_WAKE)
            wake_cnt_reg <= 11'h000;
        else if (sys_osc_tick)
            wake_cnt_reg <= wake_cnt_reg + 11'h001;
        core_reset_reg  <= (state_next == ST_HOLD);
        pc_zero_reg     <= (state_next != ST_RUN);
        sp_top_reg      <= (state_next == ST_HOLD);
        sp_zero_reg     <= (state_next == ST_WAKE);
        port_preset_reg <= (state_next == ST_HOLD);
        int_off_reg     <= (state_next == ST_HOLD);
        timer_off_reg   <= (state_next == ST_HOLD);
        wdt_clear_reg   <= (state_next == ST_HOLD);
        wake_hold_reg   <= (state_next == ST_WAKE);
    end
end

// ----------------------------------------
// register file
// ----------------------------------------
// only power-on clears these; internal resets keep them, except wdtc_reg, which full resets restore
always @(posedge ref_clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        ctrl_reg        <= `MSQ_CTRL_RESET;
        wdtc_reg        <= `MSQ_WDT_CTRL_RESET;
        timeout_flag    <= 1'b0;
        power_down_flag <= 1'b0;
        irq_st_reg      <= 4'h0;
        irq_mask_reg    <= 4'h0;
    end
    else
    begin
        // plain storage bits, bit6 never stored
        if (wr_ctrl)
        begin
            ctrl_reg[7:3] <= reg_wdata[7:3] & 5'b1_0111;
            ctrl_reg[`MSQ_CTRL_SPARE] <= reg_wdata[`MSQ_CTRL_SPARE];
        end
        // drop flag: hardware sets, zero-write clears, set wins
        if (drop_ev)
            ctrl_reg[`MSQ_CTRL_DROP_FLAG] <= 1'b1;
        else if (wr_ctrl && !reg_wdata[`MSQ_CTRL_DROP_FLAG])
            ctrl_reg[`MSQ_CTRL_DROP_FLAG] <= 1'b0;
        // soft reset flag, same discipline
        if (key_ev)
            ctrl_reg[`MSQ_CTRL_SOFT_FLAG] <= 1'b1;
        else if (wr_ctrl && !reg_wdata[`MSQ_CTRL_SOFT_FLAG])
            ctrl_reg[`MSQ_CTRL_SOFT_FLAG] <= 1'b0;
        // watchdog control restored by full resets
        if (full_ev)
            wdtc_reg <= `MSQ_WDT_CTRL_RESET;
        else if (wr_wdtc)
            wdtc_reg <= reg_wdata;
        // cause flags; drop reset leaves both unchanged
        if (wdt_run_ev || wdt_slp_ev)
            timeout_flag <= 1'b1;
        else if (flag_clear)
            timeout_flag <= 1'b0;
        if (wdt_slp_ev)
            power_down_flag <= 1'b1;
        else if (flag_clear)
            power_down_flag <= 1'b0;
        // sticky events, write one to clear, set wins
        if (wr_istat)
            irq_st_reg <= (irq_st_reg & ~reg_wdata[3:0]) | ev_vec;
        else
            irq_st_reg <= irq_st_reg | ev_vec;
        if (wr_imask)
            irq_mask_reg <= reg_wdata[3:0];
    end
end

// read mux, unmapped reads zero
always @*
begin
    case (reg_addr)
        `MSQ_ADDR_SYS_CTRL:   rd_mux = {ctrl_reg[7], 1'b0, ctrl_reg[5:0]};
        `MSQ_ADDR_WDT_CTRL:   rd_mux = wdtc_reg;
        `MSQ_ADDR_RST_STATUS: rd_mux = {6'h00, power_down_flag, timeout_flag};
        `MSQ_ADDR_IRQ_STATUS: rd_mux = {4'h0, irq_st_reg};
        `MSQ_ADDR_IRQ_MASK:   rd_mux = {4'h0, irq_mask_reg};
        default:              rd_mux = 8'h00;
    endcase
end

// ----------------------------------------
// registered outputs
// ----------------------------------------
always @(posedge ref_clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        reg_rdata         <= 8'h00;
        irq_reg           <= 1'b0;
        wdt_enable_reg    <= 1'b1;
        wdt_period_reg    <= 3'h3;
        idle_sysclk_keep  <= 1'b0;
        fast_osc_freq_sel <= 2'h0;
        crystal_low_power <= 1'b0;
    end
    else
    begin
        reg_rdata         <= reg_rd ? rd_mux : 8'h00;   // valid one cycle
        irq_reg           <= |(irq_st_reg & irq_mask_reg);
        wdt_enable_reg    <= ~key_bad;
        wdt_period_reg    <= wdtc_reg[2:0];
        idle_sysclk_keep  <= ctrl_reg[`MSQ_CTRL_SYSCLK_KEEP];
        fast_osc_freq_sel <= ctrl_reg[5:4];
        crystal_low_power <= ctrl_reg[3];
    end
end

endmodule // msq_reset_seq

// >>> testbench/msq_osc_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// oscillator tick source
// ----------------------------------------
module msq_osc_model #(
    parameter int SYS_DIV  = 4,
    parameter int SLOW_DIV = 10
) (
    input  wire  ref_clk,
    output logic sys_osc_tick,
    output logic slow_osc_tick
);
    int sys_cnt  = 0;
    int slow_cnt = 0;

    // free-running dividers, one pulse per period
    always @(posedge ref_clk)
    begin
        sys_cnt  <= (sys_cnt + 1) % SYS_DIV;
        slow_cnt <= (slow_cnt + 1) % SLOW_DIV;
    end
    assign sys_osc_tick  = (sys_cnt == SYS_DIV - 1);
    assign slow_osc_tick = (slow_cnt == SLOW_DIV - 1);
endmodule // msq_osc_model

// >>> testbench/msq_reset_seq_monitor.sv
`timescale 1ns/100ps
`include "msq_reset_map.vh"
// ----------------------------------------
// port checker of the reset sequencer
// ----------------------------------------
module msq_reset_seq_monitor #(
    parameter [23:0] POR_HOLD_CYC = 24'h00_0032,
    parameter [23:0] WDT_HOLD_CYC = 24'h00_0014
) (
    input wire       ref_clk,
    input wire       rst_b,
    input wire       sleep_mode,
    input wire       idle_mode,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    input wire       core_reset_reg,
    input wire       pc_zero_reg,
    input wire       sp_top_reg,
    input wire       sp_zero_reg,
    input wire       port_preset_reg,
    input wire       int_off_reg,
    input wire       timer_off_reg,
    input wire       wdt_clear_reg,
    input wire       wake_hold_reg,
    input wire       wdt_enable_reg,
    input wire       irq_reg
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    // core state while a full reset is held, and counter clear at its release
    pc_zero_a: assert property (core_reset_reg |-> pc_zero_reg) else $error("pc not forced");
    port_in_a: assert property (core_reset_reg |-> port_preset_reg) else $error("ports not preset");
    int_off_a: assert property (core_reset_reg |-> int_off_reg && timer_off_reg) else $error("irq or timer on");
    stack_top_a: assert property (core_reset_reg |-> sp_top_reg && !sp_zero_reg) else $error("stack not at top");
    dog_clr_a: assert property ($fell(core_reset_reg) |-> !wdt_clear_reg) else $error("counter still cleared");
    // wake from low power touches pc and stack only
    wake_pc_a: assert property (wake_hold_reg |->
        pc_zero_reg && sp_zero_reg && !core_reset_reg && !port_preset_reg) else $error("wake reset too wide");
    sleep_keep_a: assert property ((sleep_mode || idle_mode) && wdt_enable_reg && !core_reset_reg
        |=> !core_reset_reg) else $error("reset in low power");
    // register port; enable follows the stored key one edge later
    key_en_a: assert property (reg_wr && reg_addr == `MSQ_ADDR_WDT_CTRL
        && (reg_wdata[7:3] == `MSQ_KEY_A || reg_wdata[7:3] == `MSQ_KEY_B) |-> ##2 wdt_enable_reg)
        else $error("good key not enabled");
    rd_unused_a: assert property (reg_rd && reg_addr == `MSQ_ADDR_SYS_CTRL |=> !reg_rdata[6]) else $error("bit6 set");
    rd_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data outside its cycle");
    // main scenarios
    rst_seen_c: cover property ($rose(core_reset_reg));
    wake_seen_c: cover property ($rose(wake_hold_reg));
    irq_seen_c: cover property ($rose(irq_reg));
endmodule // msq_reset_seq_monitor

// >>> testbench/tb_top.sv
`timescale 1ns/100ps
`include "msq_reset_map.vh"
// ----------------------------------------
// reset sequencer testbench
// ----------------------------------------
module tb_top;
    localparam int POR = 50;
    localparam int DOG = 20;
    logic       ref_clk        = 1'b0;
    logic       rst_b          = 1'b0;
    logic       supply_low_in  = 1'b0;
    logic       wdt_timeout_in = 1'b0;
    logic       sleep_mode     = 1'b0;
    logic       idle_mode      = 1'b0;
    logic [1:0] osc_src        = 2'h0;
    logic       flag_clear     = 1'b0;
    logic [7:0] reg_addr       = 8'h00;
    logic [7:0] reg_wdata      = 8'h00;
    logic       reg_wr         = 1'b0;
    logic       reg_rd         = 1'b0;
    wire  [7:0] reg_rdata;
    wire        core_reset_reg, wake_hold_reg, irq_reg, sys_osc_tick, slow_osc_tick;
    wire  [2:0] wdt_period_reg;
    wire  [1:0] fast_osc_freq_sel;
    wire        wdt_enable_reg, idle_sysclk_keep, crystal_low_power;
    int         failures       = 0;
    int         total_checks   = 0;
    int         n;
    int         t;
    int         x;

    msq_reset_seq #(.POR_HOLD_CYC(24'(POR)), .WDT_HOLD_CYC(24'(DOG))) u_dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .supply_low_in(supply_low_in), .wdt_timeout_in(wdt_timeout_in),
        .sleep_mode(sleep_mode), .idle_mode(idle_mode), .osc_src(osc_src), .sys_osc_tick(sys_osc_tick),
        .slow_osc_tick(slow_osc_tick), .flag_clear(flag_clear), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_reset_reg(core_reset_reg),
        .pc_zero_reg(), .sp_top_reg(), .sp_zero_reg(), .port_preset_reg(), .int_off_reg(), .timer_off_reg(),
        .wdt_clear_reg(), .wake_hold_reg(wake_hold_reg), .wdt_enable_reg(wdt_enable_reg),
        .wdt_period_reg(wdt_period_reg), .idle_sysclk_keep(idle_sysclk_keep),
        .fast_osc_freq_sel(fast_osc_freq_sel), .crystal_low_power(crystal_low_power), .irq_reg(irq_reg));
    msq_osc_model u_osc (.ref_clk(ref_clk), .sys_osc_tick(sys_osc_tick), .slow_osc_tick(slow_osc_tick));

    // 200 MHz clock
    initial
    begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        chk(nm, reg_rdata & m, e);
    endtask

    task automatic bark;
        wdt_timeout_in <= 1'b1;
        @(posedge ref_clk);
        wdt_timeout_in <= 1'b0;
    endtask

    // wait for reset to rise, then count the cycles it is held
    task automatic held(output int c);
        c = 0;
        while (core_reset_reg !== 1'b1 && c < 300)
        begin
            @(posedge ref_clk);
            c++;
        end
        c = 0;
        while (core_reset_reg !== 1'b0 && c < 5000)
        begin
            @(posedge ref_clk);
            c++;
        end
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // cut a hang short
    initial
    begin
        #200000;
        failures++;
        summarize();
    end

    // main test sequence
    initial
    begin
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        held(n);
        chk("por hold", 8'(n), 8'(POR + 2));
        rd("ctrl por", `MSQ_ADDR_SYS_CTRL, 8'hFF, `MSQ_CTRL_RESET);
        rd("key por", `MSQ_ADDR_WDT_CTRL, 8'hFF, `MSQ_WDT_CTRL_RESET);
        rd("flags por", `MSQ_ADDR_RST_STATUS, 8'hFF, 8'h00);
        rd("mask por", `MSQ_ADDR_IRQ_MASK, 8'hFF, 8'h00);
        wr(8'h7F, 8'hFF);
        rd("unmapped", 8'h7F, 8'hFF, 8'h00);
        supply_low_in <= 1'b1;
        repeat (100) @(posedge ref_clk);
        supply_low_in <= 1'b0;
        repeat (20) @(posedge ref_clk);
        chk("short dip", {7'h00, core_reset_reg}, 8'h00);
        bark();
        held(n);
        chk("dog hold", 8'(n >= DOG && n <= DOG + 2), 8'h01);
        rd("flags dog", `MSQ_ADDR_RST_STATUS, 8'hFF, 8'h01);
        supply_low_in <= 1'b1;
        repeat (300) @(posedge ref_clk);
        chk("long dip", {7'h00, core_reset_reg}, 8'h01);
        supply_low_in <= 1'b0;
        held(n);
        rd("flags dip", `MSQ_ADDR_RST_STATUS, 8'hFF, 8'h01);
        rd("dip flag", `MSQ_ADDR_SYS_CTRL, 8'h04, 8'h04);
        rd("dip irq", `MSQ_ADDR_IRQ_STATUS, 8'h0F, 8'h03);
        chk("irq masked", {7'h00, irq_reg}, 8'h00);
        wr(`MSQ_ADDR_IRQ_MASK, 8'h01);
        @(posedge ref_clk);
        chk("irq set", {7'h00, irq_reg}, 8'h01);
        wr(`MSQ_ADDR_IRQ_STATUS, 8'h0F);
        @(posedge ref_clk);
        chk("irq clear", {7'h00, irq_reg}, 8'h00);
        wr(`MSQ_ADDR_SYS_CTRL, 8'h46);
        rd("ctrl ones", `MSQ_ADDR_SYS_CTRL, 8'hFF, 8'h06);
        wr(`MSQ_ADDR_SYS_CTRL, 8'hB8);
        rd("ctrl cfg", `MSQ_ADDR_SYS_CTRL, 8'hFF, 8'hB8);
        chk("cfg outs", {4'h0, idle_sysclk_keep, fast_osc_freq_sel, crystal_low_power}, 8'h0F);
        wr(`MSQ_ADDR_SYS_CTRL, 8'h00);
        rd("ctrl zeros", `MSQ_ADDR_SYS_CTRL, 8'hFF, 8'h00);
        sleep_mode    <= 1'b1;
        supply_low_in <= 1'b1;
        repeat (300) @(posedge ref_clk);
        chk("sleep dip", {7'h00, core_reset_reg}, 8'h00);
        supply_low_in <= 1'b0;
        flag_clear    <= 1'b1;
        @(posedge ref_clk);
        flag_clear <= 1'b0;
        rd("flags clr", `MSQ_ADDR_RST_STATUS, 8'hFF, 8'h00);
        // time-out in low power, one pass per oscillator source
        for (int i = 0; i < 3; i++)
        begin
            osc_src    <= 2'(i);
            sleep_mode <= (i != 1);
            idle_mode  <= (i == 1);
            x = (i == 0) ? 16 : (i == 1) ? 2 : 1024;
            bark();
            @(posedge ref_clk);
            chk("wake hold", {7'h00, wake_hold_reg}, 8'h01);
            t = 0;
            n = 0;
            while (wake_hold_reg !== 1'b0 && n < 8000)
            begin
                @(posedge ref_clk);
                t += sys_osc_tick;
                n++;
            end
            chk("wake ticks", 8'(t >= x - 1 && t <= x + 1), 8'h01);
        end
        sleep_mode <= 1'b0;
        idle_mode  <= 1'b0;
        rd("flags wake", `MSQ_ADDR_RST_STATUS, 8'hFF, 8'h03);
        wr(`MSQ_ADDR_WDT_CTRL, 8'hAD);
        rd("good key", `MSQ_ADDR_WDT_CTRL, 8'hFF, 8'hAD);
        chk("key outs", {4'h0, wdt_enable_reg, wdt_period_reg}, 8'h0D);
        wr(`MSQ_ADDR_WDT_CTRL, 8'h03);
        // the tick sampled at the return edge already counts
        t = slow_osc_tick;
        n = 0;
        while (core_reset_reg !== 1'b1 && n < 200)
        begin
            @(posedge ref_clk);
            t += slow_osc_tick;
            n++;
        end
        chk("key ticks", 8'(t >= 2 && t <= 3), 8'h01);
        held(n);
        rd("soft flag", `MSQ_ADDR_SYS_CTRL, 8'h01, 8'h01);
        rd("key back", `MSQ_ADDR_WDT_CTRL, 8'hFF, `MSQ_WDT_CTRL_RESET);
        rd("key irq", `MSQ_ADDR_IRQ_STATUS, 8'h08, 8'h08);
        summarize();
    end
endmodule // tb_top

bind msq_reset_seq msq_reset_seq_monitor #(.POR_HOLD_CYC(POR_HOLD_CYC), .WDT_HOLD_CYC(WDT_HOLD_CYC)) u_mon (
    .ref_clk(ref_clk), .rst_b(rst_b), .sleep_mode(sleep_mode), .idle_mode(idle_mode),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .core_reset_reg(core_reset_reg), .pc_zero_reg(pc_zero_reg), .sp_top_reg(sp_top_reg),
    .sp_zero_reg(sp_zero_reg), .port_preset_reg(port_preset_reg), .int_off_reg(int_off_reg),
    .timer_off_reg(timer_off_reg), .wdt_clear_reg(wdt_clear_reg), .wake_hold_reg(wake_hold_reg),
    .wdt_enable_reg(wdt_enable_reg), .irq_reg(irq_reg));
